/* bit_period_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_period_tick
    import sar_adc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic rc_tick,
    output logic half_tick
);

    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic next_half_tick;
    logic [5:0] limit;

    // ------------------------------------------------------------
    // half period length follows the select code live
    // ------------------------------------------------------------
    always_comb begin
        case (sel)
            SEL_DIV2: limit = HALF_DIV2;
            SEL_DIV4: limit = HALF_DIV4;
            SEL_DIV8: limit = HALF_DIV8;
            SEL_DIV16: limit = HALF_DIV16;
            SEL_DIV32: limit = HALF_DIV32;
            SEL_DIV64: limit = HALF_DIV64;
            default: limit = HALF_DIV2;
        endcase
    end

    // divided system clock, or the oscillator ticks when rc is chosen
    always_comb begin
        next_cnt = 6'h00;
        next_half_tick = 1'b0;
        if (run) begin
            if (sel[1:0] == SEL_RC_LOW) begin
                next_half_tick = rc_tick;
            end else if (cnt >= limit - 6'h01) begin
                next_half_tick = 1'b1;
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt <= 6'h00;
            half_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            half_tick <= next_half_tick;
        end
    end

endmodule
`default_nettype wire

/* sar_adc_pkg.sv */
package sar_adc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_CLEAR = 3'h5;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ON_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int SEL_LSB = 4;
    localparam int JUSTIFY_BIT = 7;
    localparam int DONE_BIT = 0;

    // ------------------------------------------------------------
    // reset values and first trial
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

    // ------------------------------------------------------------
    // clock select codes and half bit period lengths in system clocks
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_DIV2 = 3'h0;
    localparam logic [2:0] SEL_DIV4 = 3'h4;
    localparam logic [2:0] SEL_DIV8 = 3'h1;
    localparam logic [2:0] SEL_DIV16 = 3'h5;
    localparam logic [2:0] SEL_DIV32 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h6;
    localparam logic [1:0] SEL_RC_LOW = 2'h3;
    localparam logic [5:0] HALF_DIV2 = 6'h01;
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV8 = 6'h04;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV32 = 6'h10;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    // ------------------------------------------------------------
    // conversion timing: 11.5 bit periods = 23 half periods
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 10;
    localparam logic [4:0] HALF_FIRST_RESOLVE = 5'h04;
    localparam logic [4:0] HALF_LAST_RESOLVE = 5'h16;
    localparam logic [3:0] LAST_BIT_INDEX = 4'h9;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam logic [2:0] INSTR_CYCLE_CLKS =
        3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_t;

endpackage

/* sar_adc_sequencer_control.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_control
    import sar_adc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SLEEP,
    input wire logic RC_TICK,
    input wire logic COMP,
    output logic [9:0] TRIAL,
    output logic HOLD,
    output logic CONV_POWER,
    output logic IRQ,
    output logic WAKE
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_state_t state, next_state;
    logic converter_on, next_converter_on;
    logic go, next_go;
    logic [2:0] conv_clock_select, next_conv_clock_select;
    logic result_justify_select, next_result_justify_select;
    logic conversion_done_flag, next_conversion_done_flag;
    logic conversion_done_irq_enable, next_conversion_done_irq_enable;
    logic [9:0] result, next_result;
    logic [9:0] sar, next_sar;
    logic [3:0] nres, next_nres;
    logic [4:0] hc, next_hc;
    logic [2:0] dly, next_dly;
    logic [7:0] next_rdata;
    logic next_irq, next_wake, next_power, next_hold;
    logic half_tick;
    logic rc_sel, sleep_kill, wr_ctl, complete, abort_go, resolve;
    logic [15:0] justified;
    logic [9:0] partial;

    // ------------------------------------------------------------
    // bit period timing
    // ------------------------------------------------------------
    bit_period_tick u_tick (
        .clk(CLK),
        .resetn(RESETN),
        .run(state == ST_CONVERT),
        .sel(conv_clock_select),
        .rc_tick(RC_TICK),
        .half_tick(half_tick)
    );

    // fill unresolved bits with the last resolved one
    function automatic logic [9:0] fill_partial(input logic [9:0] v, input logic [3:0] n);
        logic [9:0] r;
        logic last;
        integer i;
        r = v;
        last = (n == 4'h0) ? 1'b0 : v[RESULT_BITS - int'(n)];
        for (i = 0; i < RESULT_BITS; i = i + 1) begin
            if (i + int'(n) < RESULT_BITS) begin
                r[i] = last;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // decode and formatting
    // ------------------------------------------------------------
    assign rc_sel = (conv_clock_select[1:0] == SEL_RC_LOW);
    assign sleep_kill = SLEEP && !rc_sel;
    assign wr_ctl = WR && (ADDR == ADDR_CONTROL);
    assign abort_go = wr_ctl && !WDATA[GO_BIT];
    assign resolve = (state == ST_CONVERT) && half_tick && (hc >= HALF_FIRST_RESOLVE) && !hc[0];
    // a write that turns the converter off or drops go, or sleep on a divided clock, beats the final resolve
    assign complete = resolve && (nres == LAST_BIT_INDEX) && !sleep_kill && !abort_go
        && !(wr_ctl && !WDATA[ON_BIT]);
    assign partial = fill_partial(sar, nres);
    assign justified = result_justify_select ? {result, 6'h00} : {6'h00, result};

    // ------------------------------------------------------------
    // sequencer and register next values
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_converter_on = converter_on;
        next_go = go;
        next_conv_clock_select = conv_clock_select;
        next_result_justify_select = result_justify_select;
        next_conversion_done_flag = conversion_done_flag;
        next_conversion_done_irq_enable = conversion_done_irq_enable;
        next_result = result;
        next_sar = sar;
        next_nres = nres;
        next_hc = hc;
        next_dly = dly;
        // software writes
        if (wr_ctl) begin
            next_converter_on = WDATA[ON_BIT];
        end
        if (WR && ADDR == ADDR_CONFIG) begin
            next_conv_clock_select = WDATA[SEL_LSB +: 3];
            next_result_justify_select = WDATA[JUSTIFY_BIT];
        end
        if (WR && ADDR == ADDR_IRQ_ENABLE) begin
            next_conversion_done_irq_enable = WDATA[DONE_BIT];
        end
        if (WR && ADDR == ADDR_CLEAR && WDATA[DONE_BIT]) begin
            next_conversion_done_flag = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                // go only takes effect when the converter was already on
                if (wr_ctl && WDATA[GO_BIT] && WDATA[ON_BIT] && converter_on && !sleep_kill) begin
                    next_go = 1'b1;
                    next_sar = SAR_FIRST_TRIAL;
                    next_nres = 4'h0;
                    next_hc = 5'h00;
                    next_dly = 3'h0;
                    next_state = rc_sel ? ST_DELAY : ST_CONVERT;
                end
            end
            ST_DELAY, ST_CONVERT: begin
                if ((wr_ctl && !WDATA[ON_BIT]) || sleep_kill) begin
                    next_go = 1'b0;
                    next_state = ST_IDLE;
                end else if (abort_go) begin
                    next_go = 1'b0;
                    next_result = partial;
                    next_state = ST_IDLE;
                end else if (state == ST_DELAY) begin
                    next_dly = dly + 3'h1;
                    if (dly == INSTR_CYCLE_CLKS - 3'h1) begin
                        next_state = ST_CONVERT;
                    end
                end else if (half_tick) begin
                    next_hc = hc + 5'h01;
                    if (resolve) begin
                        if (!COMP) begin
                            next_sar[LAST_BIT_INDEX - nres] = 1'b0;
                        end
                        if (nres != LAST_BIT_INDEX) begin
                            next_sar[LAST_BIT_INDEX - nres - 4'h1] = 1'b1;
                        end
                        next_nres = nres + 4'h1;
                    end
                    if (complete) begin
                        next_go = 1'b0;
                        next_result = next_sar;
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_go = 1'b0;
            end
        endcase
        // set wins over a clear in the same cycle
        if (complete) begin
            next_conversion_done_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs from next values, read data from current registers
    // ------------------------------------------------------------
    always_comb begin
        next_irq = next_conversion_done_flag && next_conversion_done_irq_enable;
        next_wake = next_irq && SLEEP;
        next_power = next_converter_on && !sleep_kill &&
            !(SLEEP && next_state == ST_IDLE && next_conversion_done_flag && !next_conversion_done_irq_enable);
        next_hold = (next_state == ST_CONVERT);
        next_rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                ADDR_CONTROL: next_rdata = {6'h00, go, converter_on};
                ADDR_CONFIG: next_rdata = {result_justify_select, conv_clock_select, 4'h0};
                ADDR_RESULT_HIGH: next_rdata = justified[15:8];
                ADDR_RESULT_LOW: next_rdata = justified[7:0];
                ADDR_STATUS: next_rdata = {7'h00, conversion_done_flag};
                ADDR_IRQ_ENABLE: next_rdata = {7'h00, conversion_done_irq_enable};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= ST_IDLE;
            converter_on <= 1'b0;
            go <= 1'b0;
            conv_clock_select <= SEL_RESET;
            result_justify_select <= 1'b0;
            conversion_done_flag <= 1'b0;
            conversion_done_irq_enable <= 1'b0;
            result <= RESULT_RESET;
            sar <= RESULT_RESET;
            nres <= 4'h0;
            hc <= 5'h00;
            dly <= 3'h0;
            RDATA <= 8'h00;
            IRQ <= 1'b0;
            WAKE <= 1'b0;
            CONV_POWER <= 1'b0;
            HOLD <= 1'b0;
        end else begin
            state <= next_state;
            converter_on <= next_converter_on;
            go <= next_go;
            conv_clock_select <= next_conv_clock_select;
            result_justify_select <= next_result_justify_select;
            conversion_done_flag <= next_conversion_done_flag;
            conversion_done_irq_enable <= next_conversion_done_irq_enable;
            result <= next_result;
            sar <= next_sar;
            nres <= next_nres;
            hc <= next_hc;
            dly <= next_dly;
            RDATA <= next_rdata;
            IRQ <= next_irq;
            WAKE <= next_wake;
            CONV_POWER <= next_power;
            HOLD <= next_hold;
        end
    end

    assign TRIAL = sar;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    done_timing_a: assert property (complete |-> hc == HALF_LAST_RESOLVE && nres == LAST_BIT_INDEX)
        else $error("completion not at the last half period");
    done_set_a: assert property (complete |=> conversion_done_flag && !go && result == $past(next_sar))
        else $error("completion did not set flag, clear go and load result");
    flag_flagset_a: assert property (complete |=> conversion_done_flag)
        else $error("done flag not set on completion");
    flag_sticky_a: assert property (conversion_done_flag && !(WR && ADDR == ADDR_CLEAR) |=> conversion_done_flag)
        else $error("done flag dropped without software clear");
    irq_level_a: assert property (##1 IRQ == (conversion_done_flag && conversion_done_irq_enable))
        else $error("interrupt does not match flag and enable");
    off_idle_a: assert property (!converter_on |=> state == ST_IDLE)
        else $error("conversion running with converter off");
    abort_partial_a: assert property (state != ST_IDLE && abort_go && !sleep_kill && WDATA[ON_BIT]
        |=> state == ST_IDLE && result == $past(partial))
        else $error("abort did not store partial result");
    sleep_abort_a: assert property (state != ST_IDLE && sleep_kill && !wr_ctl
        |=> state == ST_IDLE && converter_on && !CONV_POWER)
        else $error("sleep did not abort a non-rc conversion");
    rc_delay_a: assert property (state == ST_IDLE && next_state != ST_IDLE && rc_sel
        |=> state == ST_DELAY [*4] ##1 state != ST_DELAY)
        else $error("rc start delay wrong length");
    right_format_a: assert property (RD && ADDR == ADDR_RESULT_HIGH && !result_justify_select
        |=> RDATA[7:2] == 6'h00)
        else $error("right justified high byte not zero padded");
    go_off_a: assert property (!converter_on |-> !go)
        else $error("go set while converter is off");
    hold_on_a: assert property (HOLD |-> converter_on)
        else $error("sample held while converter is off");
    sleep_power_a: assert property (SLEEP && !rc_sel |=> !CONV_POWER)
        else $error("converter powered during sleep on a divided clock");
    wake_irq_a: assert property (WAKE |-> IRQ)
        else $error("wake raised without an interrupt request");
    delay_len_a: assert property (state == ST_DELAY |-> dly < INSTR_CYCLE_CLKS)
        else $error("rc start delay overran");
    first_trial_a: assert property (state == ST_CONVERT && nres == 4'h0 |-> TRIAL == SAR_FIRST_TRIAL)
        else $error("first trial is not the msb");

    conv_done_c: cover property (complete);
    conv_abort_c: cover property (state == ST_CONVERT && abort_go);
    rc_conv_c: cover property (state == ST_DELAY ##[1:300] complete);
    wake_c: cover property (WAKE);

endmodule
`default_nettype wire

/* sar_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model (
    input wire logic clk,
    input wire logic [9:0] level,
    input wire logic [9:0] trial,
    input wire logic hold,
    input wire logic power,
    output logic comp
);
    // ------------------------------------------------------------
    // track and hold, comparator
    // ------------------------------------------------------------
    logic [9:0] held;
    logic wobble = 1'b0;

    // track the input while hold is low, freeze it while hold is high
    always @(posedge clk) begin
        wobble <= ~wobble;
        if (!hold) begin
            held <= level;
        end
    end

    // unpowered or not holding: the comparator output is meaningless, so it wanders
    assign comp = (power && hold) ? (held >= trial) : wobble;
endmodule
`default_nettype wire

/* tb_sar_adc_sequencer_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module tb_sar_adc_sequencer_control;
    import sar_adc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int RC_PER = 10;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic SLEEP = 1'b0;
    logic RC_TICK = 1'b0;
    logic [7:0] RDATA;
    logic COMP;
    logic [9:0] TRIAL;
    logic HOLD, CONV_POWER, IRQ, WAKE;
    logic [9:0] level = 10'h000;
    int err_count = 0;
    int comparisons = 0;
    int seed = 26;
    int rc_cnt = 0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    logic rd_chk = 1'b0;
    logic pend = 1'b0;
    logic [2:0] codes[8] = '{SEL_DIV2, SEL_DIV4, SEL_DIV8, SEL_DIV16, SEL_DIV32, SEL_DIV64, 3'h3, 3'h7};
    int halves[8] = '{1, 2, 4, 8, 16, 32, RC_PER, RC_PER};

    sar_adc_sequencer_control i_sar_adc_sequencer_control (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .RC_TICK(RC_TICK), .COMP(COMP),
        .TRIAL(TRIAL), .HOLD(HOLD), .CONV_POWER(CONV_POWER), .IRQ(IRQ), .WAKE(WAKE));
    sar_analog_model i_sar_analog_model (.clk(CLK), .level(level), .trial(TRIAL), .hold(HOLD),
        .power(CONV_POWER), .comp(COMP));

    // system clock and free-running rc half-period ticks
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
        RC_TICK <= (rc_cnt == 0);
    end

    // read data monitor: takes the oldest note for each checked read
    always @(posedge CLK) begin
        if (pend) begin
            exp_v = exp_q.pop_front();
            `CHK(RDATA, exp_v)
        end
        pend <= RD && rd_chk;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic chk, output logic [7:0] v);
        ADDR <= a;
        RD <= 1'b1;
        rd_chk <= chk;
        @(posedge CLK);
        RD <= 1'b0;
        if (chk) exp_q.push_back(e);
        @(posedge CLK);
        v = RDATA;
    endtask

    task automatic ex(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, e, 1'b1, v);
    endtask

    // one full conversion, checked for timing, result, flags and interrupt
    task automatic conv_case(input logic [2:0] code, input logic just, input logic ie, input int h, input logic slp);
        logic [9:0] smp;
        logic [15:0] f;
        logic [7:0] v;
        int n;
        smp = 10'($random(seed));
        f = just ? {smp, 6'h00} : {6'h00, smp};
        level <= smp;
        wr(ADDR_CONFIG, {just, code, 4'h0});
        wr(ADDR_IRQ_ENABLE, {7'h00, ie});
        wr(ADDR_CONTROL, 8'h03);
        SLEEP <= slp;
        n = 0;
        v = 8'h00;
        while (v[DONE_BIT] !== 1'b1 && n < 5000) begin
            rd(ADDR_STATUS, 8'h00, 1'b0, v);
            n += 2;
        end
        // 23 half periods plus bus latency; rc adds the start delay and an unknown tick phase
        if (h == RC_PER) begin
            `CHK(n >= 23 * h - 2 && n <= 23 * h + 6, 1'b1)
        end else begin
            `CHK(n >= 23 * h + 2 && n <= 23 * h + 3, 1'b1)
        end
        `CHK(IRQ, ie)
        `CHK(WAKE, ie & slp)
        `CHK(CONV_POWER, ~(slp & ~ie))
        SLEEP <= 1'b0;
        ex(ADDR_CONTROL, 8'h01);
        ex(ADDR_RESULT_HIGH, f[15:8]);
        ex(ADDR_RESULT_LOW, f[7:0]);
        ex(ADDR_STATUS, 8'h01);
        wr(ADDR_CLEAR, 8'h01);
        ex(ADDR_STATUS, 8'h00);
        `CHK(IRQ, 1'b0)
    endtask

    task automatic end_of_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [9:0] s;
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        for (int a = 0; a < 8; a++) ex(3'(a), 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        ex(ADDR_STATUS, 8'h00);
        // go in the same write as converter-on must not start
        wr(ADDR_CONTROL, 8'h03);
        ex(ADDR_CONTROL, 8'h01);
        `CHK(CONV_POWER, 1'b1)
        `CHK(HOLD, 1'b0)
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 8'h02);
        ex(ADDR_CONTROL, 8'h00);
        `CHK(HOLD | CONV_POWER, 1'b0)
        wr(ADDR_CONTROL, 8'h01);
        for (int i = 0; i < 8; i++) conv_case(codes[i], i[0], i[1], halves[i], 1'b0);
        conv_case(3'h3, 1'b0, 1'b1, RC_PER, 1'b1);
        conv_case(3'h7, 1'b1, 1'b0, RC_PER, 1'b1);
        // software abort after a few bits resolved
        for (int k = 0; k < 2; k++) begin
            s = k ? 10'h200 : 10'h3FF;
            level <= s;
            wr(ADDR_CONFIG, {1'b0, SEL_DIV64, 4'h0});
            wr(ADDR_CONTROL, 8'h03);
            repeat (300) @(posedge CLK);
            wr(ADDR_CONTROL, 8'h01);
            ex(ADDR_CONTROL, 8'h01);
            ex(ADDR_RESULT_HIGH, {6'h00, s[9:8]});
            ex(ADDR_RESULT_LOW, s[7:0]);
            wr(ADDR_CLEAR, 8'h01);
        end
        // sleep on a divided clock aborts and powers down
        wr(ADDR_CONTROL, 8'h03);
        `CHK(TRIAL, SAR_FIRST_TRIAL)
        `CHK(HOLD & CONV_POWER, 1'b1)
        repeat (50) @(posedge CLK);
        SLEEP <= 1'b1;
        repeat (4) @(posedge CLK);
        `CHK(HOLD | CONV_POWER, 1'b0)
        ex(ADDR_CONTROL, 8'h01);
        ex(ADDR_RESULT_HIGH, 8'h02);
        SLEEP <= 1'b0;
        // reset in mid conversion
        wr(ADDR_CONFIG, {1'b1, SEL_DIV64, 4'h0});
        wr(ADDR_CONTROL, 8'h03);
        repeat (40) @(posedge CLK);
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        `CHK(HOLD | CONV_POWER | IRQ, 1'b0)
        ex(ADDR_CONTROL, 8'h00);
        ex(ADDR_CONFIG, 8'h00);
        ex(ADDR_RESULT_LOW, 8'h00);
        repeat (2) @(posedge CLK);
        end_of_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge CLK);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
